// [rtl/pcdcs_flag.sv]
// sticky write-one-to-clear status flag cell
`timescale 1ns/1ps
module pcdcs_flag (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	typedef struct packed {
		logic flag;
	} pcdcs_flag_st_t;

	pcdcs_flag_st_t st_q;
	pcdcs_flag_st_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (i_clr)
		begin
			st_d.flag = 1'b0;
		end
		if (i_set)
		begin
			st_d.flag = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_flag = st_q.flag;

	property p_set_wins;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_set |=> o_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag lost its set");

	property p_clear_only;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_flag && !i_clr) |=> o_flag;
	endproperty
	a_clear_only: assert property (p_clear_only) else $error("flag fell without clear");
endmodule

// [rtl/pcdcs_pkg.sv]
// package: register map, field layout and constants of the device control/status pair
package pcdcs_pkg;
	localparam logic [9:0]  DEV_CTRL_IDX       = 10'h048;
	localparam logic [9:0]  DEV_STAT_IDX       = 10'h04A;
	localparam logic [15:0] DEV_CTRL_RST       = 16'h0000;
	localparam logic [15:0] DEV_STAT_RST       = 16'h0000;
	localparam logic [15:0] DEV_CTRL_RW_MASK   = 16'h01EF;
	localparam logic [3:0]  DEV_STAT_W1C_MASK  = 4'hF;
	localparam int          CORR_BIT           = 0;
	localparam int          NONFATAL_BIT       = 1;
	localparam int          FATAL_BIT          = 2;
	localparam int          UNSUP_BIT          = 3;
	localparam int          RELAXED_ORDER_BIT  = 4;
	localparam int          PAYLOAD_SEL_LSB    = 5;
	localparam int          PAYLOAD_SEL_MSB    = 7;
	localparam int          EXT_TAG_BIT        = 8;
	localparam int          PHANTOM_BIT        = 9;
	localparam int          AUX_PM_BIT         = 10;
	localparam int          NO_SNOOP_BIT       = 11;
	localparam int          READ_REQ_LSB       = 12;
	localparam int          READ_REQ_MSB       = 14;
	localparam int          AUX_SEEN_BIT       = 4;
	localparam int          PENDING_BIT        = 5;
	localparam logic [2:0]  PAYLOAD_CODE_MAX   = 3'h4;
	localparam logic [11:0] PAYLOAD_MIN_BYTES  = 12'h080;
	localparam logic [11:0] READ_REQ_MAX_BYTES = 12'h080;
	localparam logic [7:0]  TAG_LIMIT_SHORT    = 8'h1F;
	localparam logic [7:0]  TAG_LIMIT_LONG     = 8'hFF;
	localparam int          ACK_LATENCY        = 1;

	// payload size in bytes for a selector code
	function automatic logic [11:0] payload_bytes(input logic [2:0] code);
		logic [11:0] b;
		b = PAYLOAD_MIN_BYTES;
		if (code <= PAYLOAD_CODE_MAX)
		begin
			b = PAYLOAD_MIN_BYTES << code;
		end
		return b;
	endfunction
endpackage

// [rtl/pcdcs_top.sv]
// device control and status register pair with wishbone slave and error gating
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module pcdcs_top (
	input  wire logic        I_CLK,
	input  wire logic        I_NRST,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [11:0] I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	input  wire logic        I_CORR_ERR,
	input  wire logic        I_NONFATAL_ERR,
	input  wire logic        I_FATAL_ERR,
	input  wire logic        I_UNSUP_REQ,
	input  wire logic        I_SEQ_TAG_DEBUG,
	input  wire logic        I_TAG_ADVANCE,
	output logic             O_CORR_ERR_MSG,
	output logic             O_NONFATAL_ERR_MSG,
	output logic             O_FATAL_ERR_MSG,
	output logic             O_UNSUP_REQ_MSG,
	output logic      [3:0]  O_ERR_SEEN,
	output logic      [11:0] O_MAX_PAYLOAD_BYTES,
	output logic      [11:0] O_MAX_READ_REQ_BYTES,
	output logic             O_ORIG_RELAXED_ORDER,
	output logic             O_ORIG_NO_SNOOP,
	output logic      [7:0]  O_TAG_LIMIT,
	output logic      [7:0]  O_NEXT_TAG
);
	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic [15:0] ctrl;
		logic [3:0]  msg;
		logic [11:0] payload;
		logic [7:0]  tag_limit;
		logic [7:0]  tag;
	} pcdcs_st_t;

	pcdcs_st_t   st_q;
	pcdcs_st_t   st_d;
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic        req;
	logic [9:0]  word_idx;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        rd_launch;
	logic        wr_fire;
	logic [15:0] wmask;
	logic [3:0]  err_in;
	logic [3:0]  flag_clr;
	logic [3:0]  flags;
	logic [15:0] stat_word;
	logic [15:0] rd_word;

	// byte lanes 0 and 1 to a 16-bit write mask
	function automatic logic [15:0] lane_mask(input logic [1:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// reset release through two stages
	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	// bus decode
	assign req       = I_WB_CYC & I_WB_STB;
	assign word_idx  = I_WB_ADR[11:2];
	assign hit_ctrl  = (word_idx == pcdcs_pkg::DEV_CTRL_IDX);
	assign hit_stat  = (word_idx == pcdcs_pkg::DEV_STAT_IDX);
	assign rd_launch = req & ~st_q.ack;
	assign wr_fire   = req & I_WB_WE & st_q.ack;
	assign wmask     = lane_mask(I_WB_SEL[1:0]);

	// error events in bit order of the status flags
	assign err_in = {I_UNSUP_REQ, I_FATAL_ERR, I_NONFATAL_ERR, I_CORR_ERR};

	// write one clears, zero leaves alone
	assign flag_clr = (wr_fire && hit_stat) ?
		(I_WB_DAT[3:0] & wmask[3:0] & pcdcs_pkg::DEV_STAT_W1C_MASK) : 4'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_flag
			pcdcs_flag u_flag (
				.i_clk   (I_CLK),
				.i_rst_n (rst_n),
				.i_set   (err_in[gi]),
				.i_clr   (flag_clr[gi]),
				.o_flag  (flags[gi])
			);
		end
	endgenerate

	// status word, aux and pending bits tied low
	always_comb
	begin
		stat_word                              = pcdcs_pkg::DEV_STAT_RST;
		stat_word[3:0]                         = flags;
		stat_word[pcdcs_pkg::AUX_SEEN_BIT]     = 1'b0;
		stat_word[pcdcs_pkg::PENDING_BIT]      = 1'b0;
	end

	// read mux, unmapped reads give zero
	always_comb
	begin
		rd_word = 16'h0000;
		if (hit_ctrl)
			rd_word = st_q.ctrl;
		else if (hit_stat)
			rd_word = stat_word;
	end

	always_comb
	begin
		st_d = st_q;
		// one wait state, ack drops after one cycle
		st_d.ack = rd_launch;
		if (rd_launch)
		begin
			st_d.rdat = {16'h0000, rd_word};
		end
		// only writable bits take data
		if (wr_fire && hit_ctrl)
		begin
			st_d.ctrl = (st_q.ctrl & ~(wmask & pcdcs_pkg::DEV_CTRL_RW_MASK))
				| (I_WB_DAT[15:0] & wmask & pcdcs_pkg::DEV_CTRL_RW_MASK);
		end
		// report gating by enables
		st_d.msg[pcdcs_pkg::CORR_BIT]     = I_CORR_ERR & st_q.ctrl[pcdcs_pkg::CORR_BIT];
		st_d.msg[pcdcs_pkg::NONFATAL_BIT] = I_NONFATAL_ERR & st_q.ctrl[pcdcs_pkg::NONFATAL_BIT];
		st_d.msg[pcdcs_pkg::FATAL_BIT]    = I_FATAL_ERR & st_q.ctrl[pcdcs_pkg::FATAL_BIT];
		st_d.msg[pcdcs_pkg::UNSUP_BIT]    = I_UNSUP_REQ & st_q.ctrl[pcdcs_pkg::UNSUP_BIT];
		// payload decode, reserved codes fall to minimum
		st_d.payload = pcdcs_pkg::payload_bytes(
			st_q.ctrl[pcdcs_pkg::PAYLOAD_SEL_MSB:pcdcs_pkg::PAYLOAD_SEL_LSB]);
		// tag range only under sequential debug
		if (I_SEQ_TAG_DEBUG && st_q.ctrl[pcdcs_pkg::EXT_TAG_BIT])
			st_d.tag_limit = pcdcs_pkg::TAG_LIMIT_LONG;
		else
			st_d.tag_limit = pcdcs_pkg::TAG_LIMIT_SHORT;
		if (I_TAG_ADVANCE)
		begin
			if (st_q.tag >= st_q.tag_limit)
				st_d.tag = 8'h00;
			else
				st_d.tag = 8'(st_q.tag + 8'h01);
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q           <= '0;
			st_q.ctrl      <= pcdcs_pkg::DEV_CTRL_RST;
			st_q.payload   <= pcdcs_pkg::PAYLOAD_MIN_BYTES;
			st_q.tag_limit <= pcdcs_pkg::TAG_LIMIT_SHORT;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign O_WB_ACK             = st_q.ack;
	assign O_WB_DAT             = st_q.rdat;
	assign O_CORR_ERR_MSG       = st_q.msg[pcdcs_pkg::CORR_BIT];
	assign O_NONFATAL_ERR_MSG   = st_q.msg[pcdcs_pkg::NONFATAL_BIT];
	assign O_FATAL_ERR_MSG      = st_q.msg[pcdcs_pkg::FATAL_BIT];
	assign O_UNSUP_REQ_MSG      = st_q.msg[pcdcs_pkg::UNSUP_BIT];
	assign O_ERR_SEEN           = flags;
	assign O_MAX_PAYLOAD_BYTES  = st_q.payload;
	assign O_MAX_READ_REQ_BYTES = pcdcs_pkg::READ_REQ_MAX_BYTES;
	assign O_ORIG_RELAXED_ORDER = st_q.ctrl[pcdcs_pkg::RELAXED_ORDER_BIT];
	assign O_ORIG_NO_SNOOP      = st_q.ctrl[pcdcs_pkg::NO_SNOOP_BIT];
	assign O_TAG_LIMIT          = st_q.tag_limit;
	assign O_NEXT_TAG           = st_q.tag;

	// bus handshake, error gating, payload, tag and register field checks
	sequence s_req_new;
		req && !O_WB_ACK;
	endsequence

	sequence s_ctrl_wr;
		wr_fire && hit_ctrl && I_WB_SEL[0];
	endsequence

	sequence s_ctrl_rd;
		O_WB_ACK && !I_WB_WE && hit_ctrl;
	endsequence

	sequence s_stat_rd;
		O_WB_ACK && !I_WB_WE && hit_stat;
	endsequence

	property p_ack_timing;
		@(posedge I_CLK) disable iff (!rst_n)
		s_req_new |=> O_WB_ACK ##1 !O_WB_ACK;
	endproperty
	a_ack_timing: assert property (p_ack_timing) else $error("ack not one cycle after request");

	property p_corr_gate;
		@(posedge I_CLK) disable iff (!rst_n)
		O_CORR_ERR_MSG |-> $past(I_CORR_ERR) && $past(st_q.ctrl[pcdcs_pkg::CORR_BIT]);
	endproperty
	a_corr_gate: assert property (p_corr_gate) else $error("correctable report while disabled");

	property p_nonfatal_gate;
		@(posedge I_CLK) disable iff (!rst_n)
		(I_NONFATAL_ERR && st_q.ctrl[pcdcs_pkg::NONFATAL_BIT]) |=> O_NONFATAL_ERR_MSG;
	endproperty
	a_nonfatal_gate: assert property (p_nonfatal_gate) else $error("non-fatal report missing");

	property p_fatal_gate;
		@(posedge I_CLK) disable iff (!rst_n)
		!st_q.ctrl[pcdcs_pkg::FATAL_BIT] |=> !O_FATAL_ERR_MSG;
	endproperty
	a_fatal_gate: assert property (p_fatal_gate) else $error("fatal report while disabled");

	property p_unsup_gate;
		@(posedge I_CLK) disable iff (!rst_n)
		O_UNSUP_REQ_MSG |-> $past(I_UNSUP_REQ) && O_ERR_SEEN[pcdcs_pkg::UNSUP_BIT];
	endproperty
	a_unsup_gate: assert property (p_unsup_gate) else $error("unsupported report without event");

	property p_ctrl_ro_read;
		@(posedge I_CLK) disable iff (!rst_n)
		s_ctrl_rd |-> O_WB_DAT[pcdcs_pkg::RELAXED_ORDER_BIT] == 1'b0
			&& O_WB_DAT[pcdcs_pkg::NO_SNOOP_BIT] == 1'b0;
	endproperty
	a_ctrl_ro_read: assert property (p_ctrl_ro_read) else $error("ordering or snoop bit read one");

	property p_payload_sel;
		@(posedge I_CLK) disable iff (!rst_n)
		s_ctrl_wr ##2 1'b1 |-> O_MAX_PAYLOAD_BYTES
			== pcdcs_pkg::payload_bytes(
				$past(I_WB_DAT[pcdcs_pkg::PAYLOAD_SEL_MSB:pcdcs_pkg::PAYLOAD_SEL_LSB], 2));
	endproperty
	a_payload_sel: assert property (p_payload_sel) else $error("payload size wrong after write");

	property p_payload_rsvd;
		@(posedge I_CLK) disable iff (!rst_n)
		(st_q.ctrl[pcdcs_pkg::PAYLOAD_SEL_MSB:pcdcs_pkg::PAYLOAD_SEL_LSB] > pcdcs_pkg::PAYLOAD_CODE_MAX)
			|=> O_MAX_PAYLOAD_BYTES == pcdcs_pkg::PAYLOAD_MIN_BYTES;
	endproperty
	a_payload_rsvd: assert property (p_payload_rsvd) else $error("reserved code not minimum");

	property p_tag_range;
		@(posedge I_CLK) disable iff (!rst_n)
		1'b1 |=> O_TAG_LIMIT == (($past(I_SEQ_TAG_DEBUG) && $past(st_q.ctrl[pcdcs_pkg::EXT_TAG_BIT]))
			? pcdcs_pkg::TAG_LIMIT_LONG : pcdcs_pkg::TAG_LIMIT_SHORT);
	endproperty
	a_tag_range: assert property (p_tag_range) else $error("tag limit mismatch");

	property p_tag_bound;
		@(posedge I_CLK) disable iff (!rst_n)
		(I_TAG_ADVANCE && O_NEXT_TAG >= O_TAG_LIMIT) |=> O_NEXT_TAG == 8'h00;
	endproperty
	a_tag_bound: assert property (p_tag_bound) else $error("tag passed its limit");

	property p_tag_step;
		@(posedge I_CLK) disable iff (!rst_n)
		(I_TAG_ADVANCE && O_NEXT_TAG < O_TAG_LIMIT) |=> O_NEXT_TAG == 8'($past(O_NEXT_TAG) + 8'h01);
	endproperty
	a_tag_step: assert property (p_tag_step) else $error("tag did not step by one");

	property p_phantom_zero;
		@(posedge I_CLK) disable iff (!rst_n)
		s_ctrl_rd |-> O_WB_DAT[pcdcs_pkg::PHANTOM_BIT] == 1'b0;
	endproperty
	a_phantom_zero: assert property (p_phantom_zero) else $error("phantom enable read one");

	property p_auxpm_zero;
		@(posedge I_CLK) disable iff (!rst_n)
		s_ctrl_rd |-> O_WB_DAT[pcdcs_pkg::AUX_PM_BIT] == 1'b0;
	endproperty
	a_auxpm_zero: assert property (p_auxpm_zero) else $error("aux pm enable read one");

	property p_no_snoop_out;
		@(posedge I_CLK) disable iff (!rst_n)
		!O_ORIG_NO_SNOOP && !O_ORIG_RELAXED_ORDER;
	endproperty
	a_no_snoop_out: assert property (p_no_snoop_out) else $error("originated attribute set");

	property p_read_req_zero;
		@(posedge I_CLK) disable iff (!rst_n)
		s_ctrl_rd |-> O_WB_DAT[pcdcs_pkg::READ_REQ_MSB:pcdcs_pkg::READ_REQ_LSB] == 3'h0
			&& O_MAX_READ_REQ_BYTES == pcdcs_pkg::READ_REQ_MAX_BYTES;
	endproperty
	a_read_req_zero: assert property (p_read_req_zero) else $error("read request size nonzero");

	property p_err_logged;
		@(posedge I_CLK) disable iff (!rst_n)
		(I_FATAL_ERR && !st_q.ctrl[pcdcs_pkg::FATAL_BIT]) |=> O_ERR_SEEN[pcdcs_pkg::FATAL_BIT]
			&& !O_FATAL_ERR_MSG;
	endproperty
	a_err_logged: assert property (p_err_logged) else $error("fatal not logged while disabled");

	property p_unsup_logged;
		@(posedge I_CLK) disable iff (!rst_n)
		I_UNSUP_REQ |=> O_ERR_SEEN[pcdcs_pkg::UNSUP_BIT] [*1] ##1 1'b1;
	endproperty
	a_unsup_logged: assert property (p_unsup_logged) else $error("unsupported request not logged");

	property p_w1c;
		@(posedge I_CLK) disable iff (!rst_n)
		(wr_fire && hit_stat && I_WB_SEL[0] && I_WB_DAT[pcdcs_pkg::CORR_BIT] && !I_CORR_ERR)
			|=> !O_ERR_SEEN[pcdcs_pkg::CORR_BIT];
	endproperty
	a_w1c: assert property (p_w1c) else $error("written one did not clear flag");

	property p_w0_keeps;
		@(posedge I_CLK) disable iff (!rst_n)
		(wr_fire && hit_stat && O_ERR_SEEN[pcdcs_pkg::NONFATAL_BIT] && !I_WB_DAT[pcdcs_pkg::NONFATAL_BIT])
			|=> O_ERR_SEEN[pcdcs_pkg::NONFATAL_BIT];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) else $error("written zero cleared flag");

	property p_stat_ro;
		@(posedge I_CLK) disable iff (!rst_n)
		s_stat_rd |-> O_WB_DAT[15:4] == 12'h000 && O_WB_DAT[3:0] == $past(O_ERR_SEEN);
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status upper bits or flags wrong");

	property p_rsvd_ctrl;
		@(posedge I_CLK) disable iff (!rst_n)
		(st_q.ctrl & ~pcdcs_pkg::DEV_CTRL_RW_MASK) == 16'h0000;
	endproperty
	a_rsvd_ctrl: assert property (p_rsvd_ctrl) else $error("read-only control bit took a write");

	property p_unmapped;
		@(posedge I_CLK) disable iff (!rst_n)
		(O_WB_ACK && !hit_ctrl && !hit_stat) |-> O_WB_DAT == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// [tb/test_pcie_device_ctrl_status.sv]
// self-checking bench for the device control and status register pair
`timescale 1ns/1ps
module test_pcie_device_ctrl_status;
	localparam logic [11:0] CTRL_ADR = 12'h120;
	localparam logic [11:0] STAT_ADR = 12'h128;
	localparam logic [11:0] VOID_ADR = 12'h124;
	logic        clk;
	logic        nrst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  ev;
	logic        dbg;
	logic        adv;
	logic [3:0]  msg;
	logic [3:0]  seen;
	logic [11:0] payload;
	logic [11:0] rreq;
	logic        ro_out;
	logic        ns_out;
	logic [7:0]  tlim;
	logic [7:0]  tag;
	int          num_errors;
	int          comparisons;
	integer      seed;
	logic [3:0]  flags;
	logic [3:0]  e;
	logic [3:0]  s;
	logic [31:0] d;
	logic [31:0] rd;
	logic [15:0] ctl;
	logic [7:0]  exp_tag;
	logic [7:0]  lim;

	pcdcs_top dut (
		.I_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
		.I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
		.I_CORR_ERR(ev[0]), .I_NONFATAL_ERR(ev[1]), .I_FATAL_ERR(ev[2]), .I_UNSUP_REQ(ev[3]),
		.I_SEQ_TAG_DEBUG(dbg), .I_TAG_ADVANCE(adv),
		.O_CORR_ERR_MSG(msg[0]), .O_NONFATAL_ERR_MSG(msg[1]),
		.O_FATAL_ERR_MSG(msg[2]), .O_UNSUP_REQ_MSG(msg[3]),
		.O_ERR_SEEN(seen), .O_MAX_PAYLOAD_BYTES(payload), .O_MAX_READ_REQ_BYTES(rreq),
		.O_ORIG_RELAXED_ORDER(ro_out), .O_ORIG_NO_SNOOP(ns_out),
		.O_TAG_LIMIT(tlim), .O_NEXT_TAG(tag)
	);

	task automatic give_verdict();
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_pin(input string name, input logic [11:0] exp, input logic [11:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one classic cycle, entered just after a rising edge
	task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] sl, input logic [31:0] dt,
		output logic [31:0] q);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= sl;
		wdat <= dt;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1)
		begin
			num_errors++;
			give_verdict();
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [3:0] sl, input logic [31:0] dt);
		logic [31:0] q;
		wb(1'b1, a, sl, dt, q);
	endtask

	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		wb(1'b0, a, 4'hF, 32'h0, rd);
		chk_reg(name, exp, rd);
	endtask

	function automatic logic [11:0] exp_payload(input int c);
		return (c > 4) ? 12'h080 : 12'(128 << c);
	endfunction

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 12'h000;
		sel = 4'h0;
		wdat = 32'h0;
		ev = 4'h0;
		dbg = 1'b0;
		adv = 1'b0;
		num_errors = 0;
		comparisons = 0;
		seed = 32'h26AB;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk_pin("payload", 12'h080, payload);
		chk_pin("read_req", 12'h080, rreq);
		chk_pin("relaxed", 12'h000, {11'h0, ro_out});
		chk_pin("no_snoop", 12'h000, {11'h0, ns_out});
		chk_pin("tag_limit", 12'h01F, {4'h0, tlim});
		rd_chk("ctrl", CTRL_ADR, 32'h0);
		rd_chk("status", STAT_ADR, 32'h0);
		// read-only, reserved and unmapped places
		wr(CTRL_ADR, 4'hF, 32'hFFFF_FFFF);
		rd_chk("ctrl", CTRL_ADR, 32'h0000_01EF);
		chk_pin("relaxed", 12'h000, {11'h0, ro_out});
		chk_pin("no_snoop", 12'h000, {11'h0, ns_out});
		wr(STAT_ADR, 4'hF, 32'hFFFF_FFFF);
		rd_chk("status", STAT_ADR, 32'h0);
		wr(VOID_ADR, 4'hF, 32'hFFFF_FFFF);
		rd_chk("unmapped", VOID_ADR, 32'h0);
		wr(CTRL_ADR, 4'h2, 32'h0);
		rd_chk("ctrl", CTRL_ADR, 32'h0000_00EF);
		// every payload code
		for (int c = 0; c < 8; c++)
		begin
			wr(CTRL_ADR, 4'h1, 32'(c << 5));
			repeat (3) @(posedge clk);
			chk_pin("payload", exp_payload(c), payload);
			rd_chk("ctrl", CTRL_ADR, 32'(c << 5));
		end
		// error events against random enables, random clears
		flags = 4'h0;
		for (int i = 0; i < 60; i++)
		begin
			ctl = (i == 0) ? 16'h0 : (i == 1) ? 16'hF : 16'($random(seed)) & 16'h000F;
			e = (i < 2) ? 4'hF : 4'($random(seed));
			wr(CTRL_ADR, 4'h1, {16'h0, ctl});
			ev <= e;
			@(posedge clk);
			ev <= 4'h0;
			@(posedge clk);
			flags = flags | e;
			chk_pin("report", {8'h0, e & ctl[3:0]}, {8'h0, msg});
			chk_pin("seen", {8'h0, flags}, {8'h0, seen});
			rd_chk("status", STAT_ADR, {28'h0, flags});
			s = 4'($random(seed));
			d = $random(seed);
			wr(STAT_ADR, s, d);
			if (s[0])
				flags = flags & ~d[3:0];
			rd_chk("status", STAT_ADR, {28'h0, flags});
		end
		// event and clear in one cycle: the event wins
		ev <= 4'hF;
		wr(STAT_ADR, 4'h1, 32'h0000_000F);
		ev <= 4'h0;
		rd_chk("status", STAT_ADR, 32'h0000_000F);
		// mid-run reset clears flags and control
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk_pin("seen", 12'h000, {8'h0, seen});
		chk_pin("payload", 12'h080, payload);
		rd_chk("ctrl", CTRL_ADR, 32'h0);
		// tag ranges: debug with bit 8, bit 8 alone, debug alone
		exp_tag = 8'h00;
		for (int p = 0; p < 3; p++)
		begin
			wr(CTRL_ADR, 4'h2, (p == 2) ? 32'h0 : 32'h100);
			dbg <= (p != 1);
			lim = (p == 0) ? 8'hFF : 8'h1F;
			repeat (4) @(posedge clk);
			chk_pin("tag_limit", {4'h0, lim}, {4'h0, tlim});
			for (int i = 0; i < 600; i++)
			begin
				chk_pin("tag", {4'h0, exp_tag}, {4'h0, tag});
				if (adv)
					exp_tag = (exp_tag >= lim) ? 8'h00 : exp_tag + 8'h01;
				adv <= (($random(seed) & 3) != 0);
				@(posedge clk);
			end
			if (adv)
				exp_tag = (exp_tag >= lim) ? 8'h00 : exp_tag + 8'h01;
			adv <= 1'b0;
		end
		give_verdict();
	end
endmodule
